// ===== core/sbw_map.vh
`ifndef SBW_MAP_VH
`define SBW_MAP_VH
// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define SBW_ADDR_PLEN_CH1   10'h107
`define SBW_ADDR_PLEN_CH2   10'h127
`define SBW_ADDR_LINK_SETUP 10'h1C8
`define SBW_ADDR_TARGET_SEL 10'h3FF
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBW_RST_PLEN        16'h0000
`define SBW_RST_LINK_SETUP  16'h000A
`define SBW_RST_TARGET_SEL  16'h0000
// ----------------------------------------
// Command word fields
// ----------------------------------------
`define SBW_CMD_DIR_BIT     15
`define SBW_CMD_ADDR_HI     14
`define SBW_CMD_ADDR_LO     5
`define SBW_CMD_CNT_HI      4
`define SBW_CMD_CNT_LO      0
// ----------------------------------------
// Link setup fields
// ----------------------------------------
`define SBW_SETUP_MODE_BIT  5
`define SBW_SETUP_WDOG_HI   4
`define SBW_SETUP_WDOG_LO   0
// ----------------------------------------
// Long frame targets
// ----------------------------------------
`define SBW_TGT_PROG1       3'h1
`define SBW_TGT_PROG2       3'h2
`define SBW_TGT_PROG_BOTH   3'h3
`define SBW_TGT_DATA_BOTH   3'h4
`define SBW_DATA_LONG_MAX   16'h0080
// ----------------------------------------
// Reply pattern and timing
// ----------------------------------------
`define SBW_CHECK_PATTERN   13'h1555
`define SBW_WDOG_UNIT       32768
`define SBW_WORD_BITS       16
`endif

// ===== core/sbw_shifter.v
`timescale 1ns/1ns
// ----------------------------------------
// Serial word shifter, sampled link clock
// ----------------------------------------
module sbw_shifter #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_b,
    // Link pins
    input  wire             sckPin,
    input  wire             csPin_b,
    input  wire             mosiPin,
    output reg              misoOut_q,
    // Word side
    input  wire [WIDTH-1:0] txWord,
    output reg  [WIDTH-1:0] rxWord_q,
    output reg              rxValid_q,
    output reg              wordErr_q,
    output reg              csActive_q,
    output reg              linkActivity_q
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    reg  [1:0]       sckSync_q;
    reg  [1:0]       csSync_q;
    reg  [1:0]       mosiSync_q;
    reg              sckLast_q;
    reg  [4:0]       bitCnt_q;
    reg  [WIDTH-1:0] shiftIn_q;
    reg  [WIDTH-1:0] shiftOut_q;
    wire             sckRise;
    wire             sckFall;
    wire             csLow;

    assign sckRise = sckSync_q[1] & ~sckLast_q;
    assign sckFall = ~sckSync_q[1] & sckLast_q;
    assign csLow   = ~csSync_q[1];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sckSync_q      <= 2'h0;
            csSync_q       <= 2'h3;
            mosiSync_q     <= 2'h0;
            sckLast_q      <= 1'b0;
            bitCnt_q       <= 5'h00;
            shiftIn_q      <= {WIDTH{1'b0}};
            shiftOut_q     <= {WIDTH{1'b0}};
            misoOut_q      <= 1'b0;
            rxWord_q       <= {WIDTH{1'b0}};
            rxValid_q      <= 1'b0;
            wordErr_q      <= 1'b0;
            csActive_q     <= 1'b0;
            linkActivity_q <= 1'b0;
        end else begin
            sckSync_q      <= {sckSync_q[0], sckPin};
            csSync_q       <= {csSync_q[0], csPin_b};
            mosiSync_q     <= {mosiSync_q[0], mosiPin};
            sckLast_q      <= sckSync_q[1];
            csActive_q     <= csLow;
            rxValid_q      <= 1'b0;
            wordErr_q      <= 1'b0;
            linkActivity_q <= csLow & (sckRise | sckFall);
            if (!csLow) begin
                // Partial word at deselect is a bit-count fault
                if (bitCnt_q != 5'h00)
                    wordErr_q <= 1'b1;
                bitCnt_q   <= 5'h00;
                // Top bit already stands on the pin
                shiftOut_q <= {txWord[WIDTH-2:0], 1'b0};
                misoOut_q  <= txWord[WIDTH-1];
            end else begin
                if (sckRise) begin
                    // MSB first on both lines
                    shiftIn_q <= {shiftIn_q[WIDTH-2:0], mosiSync_q[1]};
                    if (bitCnt_q == WIDTH - 1) begin
                        rxWord_q   <= {shiftIn_q[WIDTH-2:0], mosiSync_q[1]};
                        rxValid_q  <= 1'b1;
                        bitCnt_q   <= 5'h00;
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                if (sckFall) begin
                    if (bitCnt_q == 5'h00) begin
                        shiftOut_q <= {txWord[WIDTH-2:0], 1'b0};
                        misoOut_q  <= txWord[WIDTH-1];
                    end else begin
                        shiftOut_q <= {shiftOut_q[WIDTH-2:0], 1'b0};
                        misoOut_q  <= shiftOut_q[WIDTH-1];
                    end
                end
            end
        end
    end
endmodule

// ===== core/sbw_skid.v
`timescale 1ns/1ns
// ----------------------------------------
// Two-entry buffer
// ----------------------------------------
module sbw_skid #(
    parameter WIDTH = 26
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_b,
    // Fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] slot_q [0:1];
    reg             rdPtr_q;
    reg             wrPtr_q;
    reg [1:0]       count_q;
    wire            push;
    wire            pop;

    assign inReady  = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData  = slot_q[rdPtr_q];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            slot_q[0] <= {WIDTH{1'b0}};
            slot_q[1] <= {WIDTH{1'b0}};
            rdPtr_q   <= 1'b0;
            wrPtr_q   <= 1'b0;
            count_q   <= 2'h0;
        end else begin
            if (push) begin
                slot_q[wrPtr_q] <= inData;
                wrPtr_q         <= ~wrPtr_q;
            end
            if (pop)
                rdPtr_q <= ~rdPtr_q;
            if (push & ~pop)
                count_q <= count_q + 2'h1;
            else if (pop & ~push)
                count_q <= count_q - 2'h1;
        end
    end
endmodule

// ===== core/sbw_write_protocol.v
`timescale 1ns/1ns
// Notes on behaviour
// - Write frame is two to thirty-two sixteen-bit words.
// - MISO returns thirteen-bit check pattern plus three error flags each word.
// - Every word shifts most significant bit first on both lines.
// - Command: bit 15 direction, bits 14..5 address, bits 4..0 count.
// - Mode A: gap between words beyond watchdog time enters error state.
// - Zero count and zero address starts long frame chosen by target select.
// - Target 001 writes channel-one program memory, length from its register.
// - Target 010 writes channel-two program memory, length from its register.
// - Target 011 writes both program memories, channel-one length.
// - Target 100 writes both data memories, at most 128 words.
// - Other target values: long-frame command ignored, no writes.
// - After announced words arrive, return idle; next word is a command.
// - First word at start address, each next at next higher address.
// - Framing select bit: zero means mode A, one mode B.
// - Watchdog limit is clock period times 32768 times field plus one.
// - After reset and each transfer, wait for command before data.
// - Mode A timeout before all words arrive raises burst-length flag.
`include "sbw_map.vh"
module sbw_write_protocol #(
    parameter WDOG_UNIT = `SBW_WDOG_UNIT
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // Serial link pins
    input  wire        sckPin,
    input  wire        csPin_b,
    input  wire        mosiPin,
    output reg         misoPin_q,
    // Write port towards registers and memories
    output reg         wrValid_q,
    output reg  [9:0]  wrAddr_q,
    output reg  [15:0] wrData_q,
    output reg  [2:0]  wrTarget_q,
    input  wire        wrReady,
    // Status and error control
    input  wire        clockMissing,
    input  wire        errClear,
    output reg         errState_q,
    output reg  [2:0]  errFlags_q,
    output reg         modeB_q
);
    // ----------------------------------------
    // States and locals
    // ----------------------------------------
    localparam ST_IDLE  = 2'h0;
    localparam ST_DATA  = 2'h1;
    localparam ST_ERROR = 2'h2;
    localparam BUF_W    = 10 + 16 + 3;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [9:0]  addr_q;
    reg  [15:0] wordsLeft_q;
    reg  [2:0]  frameTgt_q;
    reg  [15:0] progLenCh1_q;
    reg  [15:0] progLenCh2_q;
    reg  [15:0] linkSetup_q;
    reg  [15:0] targetSel_q;
    reg  [22:0] wdogCnt_q;
    reg         lenErr_q;
    reg         wordErrSt_q;
    reg         ckMissSync0_q;
    reg         ckMissSync1_q;

    wire [15:0] rxWord;
    wire        rxValid;
    wire        wordErr;
    wire        csActive;
    wire        linkActivity;
    wire        misoBit;
    wire [15:0] replyWord;
    wire        bufInReady;
    wire        bufOutValid;
    wire [BUF_W-1:0] bufOutData;
    wire        takeData;
    wire [9:0]  cmdAddr;
    wire [4:0]  cmdCnt;
    wire [22:0] wdogLimit;

    // Reply word: fixed pattern over three latched error flags
    assign replyWord = {`SBW_CHECK_PATTERN, errFlags_q};
    assign cmdAddr   = rxWord[`SBW_CMD_ADDR_HI:`SBW_CMD_ADDR_LO];
    assign cmdCnt    = rxWord[`SBW_CMD_CNT_HI:`SBW_CMD_CNT_LO];
    // Limit in cycles
    assign wdogLimit = wdogLen(linkSetup_q[`SBW_SETUP_WDOG_HI:`SBW_SETUP_WDOG_LO]);
    // Data words are dropped unless the buffer can take them
    assign takeData  = rxValid & (state_q == ST_DATA) & bufInReady;

    function [22:0] wdogLen;
        input [4:0] field;
        begin
            wdogLen = (({18'h0_0000, field}) + 23'h00_0001) * WDOG_UNIT[22:0];
        end
    endfunction

    // Long frame length from target select
    function [15:0] longLen;
        input [2:0]  tgt;
        input [15:0] len1;
        input [15:0] len2;
        begin
            case (tgt)
                `SBW_TGT_PROG1:     longLen = len1;
                `SBW_TGT_PROG2:     longLen = len2;
                `SBW_TGT_PROG_BOTH: longLen = len1;
                `SBW_TGT_DATA_BOTH: longLen = `SBW_DATA_LONG_MAX;
                default:            longLen = 16'h0000;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Serial shifter
    // ----------------------------------------
    sbw_shifter #(
        .WIDTH          (16)
    ) u_shifter (
        .clock          (clock),
        .rst_b          (rst_b),
        .sckPin         (sckPin),
        .csPin_b        (csPin_b),
        .mosiPin        (mosiPin),
        .misoOut_q      (misoBit),
        .txWord         (replyWord),
        .rxWord_q       (rxWord),
        .rxValid_q      (rxValid),
        .wordErr_q      (wordErr),
        .csActive_q     (csActive),
        .linkActivity_q (linkActivity)
    );

    // ----------------------------------------
    // Write buffer: a stalled sink loses no word of the first three; later words are dropped
    // ----------------------------------------
    sbw_skid #(
        .WIDTH    (BUF_W)
    ) u_skid (
        .clock    (clock),
        .rst_b    (rst_b),
        .inValid  (takeData),
        .inReady  (bufInReady),
        .inData   ({addr_q, rxWord, frameTgt_q}),
        .outValid (bufOutValid),
        .outReady (wrReady | ~wrValid_q),
        .outData  (bufOutData)
    );

    // ----------------------------------------
    // Protocol state machine
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // Direction bit must be write; reads are not handled here
                if (rxValid && !rxWord[`SBW_CMD_DIR_BIT]) begin
                    if (cmdCnt != 5'h00)
                        state_d = ST_DATA;
                    else if (cmdAddr == 10'h000 &&
                             longLen(targetSel_q[2:0], progLenCh1_q, progLenCh2_q)
                             != 16'h0000)
                        state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (lenErr_q || wordErrSt_q)
                    state_d = ST_ERROR;
                else if (takeData && wordsLeft_q == 16'h0001)
                    state_d = ST_IDLE;
            end
            ST_ERROR: begin
                if (errClear)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q       <= ST_IDLE;
            addr_q        <= 10'h000;
            wordsLeft_q   <= 16'h0000;
            frameTgt_q    <= 3'h0;
            wdogCnt_q     <= 23'h00_0000;
            lenErr_q      <= 1'b0;
            wordErrSt_q   <= 1'b0;
            ckMissSync0_q <= 1'b0;
            ckMissSync1_q <= 1'b0;
        end else begin
            state_q       <= state_d;
            ckMissSync0_q <= clockMissing;
            ckMissSync1_q <= ckMissSync0_q;
            lenErr_q      <= 1'b0;
            wordErrSt_q   <= wordErr & (state_q == ST_DATA);
            if (state_q == ST_IDLE && rxValid && !rxWord[`SBW_CMD_DIR_BIT]) begin
                wdogCnt_q <= 23'h00_0000;
                if (cmdCnt != 5'h00) begin
                    addr_q      <= cmdAddr;
                    wordsLeft_q <= {11'h000, cmdCnt};
                    frameTgt_q  <= 3'h0;
                end else begin
                    addr_q      <= 10'h000;
                    wordsLeft_q <= longLen(targetSel_q[2:0], progLenCh1_q, progLenCh2_q);
                    frameTgt_q  <= targetSel_q[2:0];
                end
            end else if (state_q == ST_DATA) begin
                if (takeData) begin
                    addr_q      <= addr_q + 10'h001;
                    wordsLeft_q <= wordsLeft_q - 16'h0001;
                end
                // Gap timer, with or without chip select held
                if (rxValid || linkActivity)
                    wdogCnt_q <= 23'h00_0000;
                else if (!modeB_q && wdogCnt_q >= wdogLimit)
                    lenErr_q <= 1'b1;
                else
                    wdogCnt_q <= wdogCnt_q + 23'h00_0001;
            end
        end
    end

    // ----------------------------------------
    // Error flags, latched until cleared
    // ----------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            errFlags_q <= 3'h0;
            errState_q <= 1'b0;
        end else begin
            errState_q <= (state_d == ST_ERROR);
            // First error locks out later ones; with no flag set, a new error wins over a clear in the same cycle
            if (errFlags_q == 3'h0) begin
                if (ckMissSync1_q && csActive)
                    errFlags_q <= 3'h4;
                else if (lenErr_q)
                    errFlags_q <= 3'h2;
                else if (wordErrSt_q)
                    errFlags_q <= 3'h1;
            end else if (errClear) begin
                errFlags_q <= 3'h0;
            end
        end
    end

    // ----------------------------------------
    // Own registers and write port
    // ----------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            progLenCh1_q <= `SBW_RST_PLEN;
            progLenCh2_q <= `SBW_RST_PLEN;
            linkSetup_q  <= `SBW_RST_LINK_SETUP;
            targetSel_q  <= `SBW_RST_TARGET_SEL;
            modeB_q      <= 1'b0;
            wrValid_q    <= 1'b0;
            wrAddr_q     <= 10'h000;
            wrData_q     <= 16'h0000;
            wrTarget_q   <= 3'h0;
            misoPin_q    <= 1'b0;
        end else begin
            misoPin_q <= misoBit;
            modeB_q   <= linkSetup_q[`SBW_SETUP_MODE_BIT];
            if (wrValid_q && wrReady)
                wrValid_q <= 1'b0;
            // Error state blocks new write requests; the buffer still pops, so queued words are dropped
            if (bufOutValid && (wrReady || !wrValid_q) && !errState_q) begin
                wrValid_q  <= 1'b1;
                wrAddr_q   <= bufOutData[BUF_W-1:19];
                wrData_q   <= bufOutData[18:3];
                wrTarget_q <= bufOutData[2:0];
                // Plain bursts also land in the block's own registers
                if (bufOutData[2:0] == 3'h0) begin
                    case (bufOutData[BUF_W-1:19])
                        `SBW_ADDR_PLEN_CH1:   progLenCh1_q <= bufOutData[18:3];
                        `SBW_ADDR_PLEN_CH2:   progLenCh2_q <= bufOutData[18:3];
                        `SBW_ADDR_LINK_SETUP: linkSetup_q  <= bufOutData[18:3];
                        `SBW_ADDR_TARGET_SEL: targetSel_q  <= bufOutData[18:3];
                        default:              targetSel_q  <= targetSel_q;
                    endcase
                end
            end
        end
    end
endmodule

// ===== verification/sbw_props.sv
`timescale 1ns/1ns
`include "sbw_map.vh"
module sbw_props #(
    parameter WDOG_UNIT = 32768
) (
    // Clock and reset
    input wire        clock,
    input wire        rst_b,
    // Link pins
    input wire        sckPin,
    input wire        csPin_b,
    input wire        mosiPin,
    input wire        misoPin_q,
    // Write port
    input wire        wrValid_q,
    input wire [9:0]  wrAddr_q,
    input wire [15:0] wrData_q,
    input wire [2:0]  wrTarget_q,
    input wire        wrReady,
    // Status
    input wire        clockMissing,
    input wire        errClear,
    input wire        errState_q,
    input wire [2:0]  errFlags_q,
    input wire        modeB_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence sStall;
        wrValid_q && !wrReady;
    endsequence
    sequence sClear;
        errClear && (errFlags_q != 3'b000);
    endsequence
    sequence sMissing;
        (clockMissing && !csPin_b && !errClear) [*5];
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_WR_HOLD: assert property (
        sStall |=> wrValid_q && $stable(wrAddr_q) && $stable(wrData_q) && $stable(wrTarget_q))
        else $error("write request changed while stalled");
    AST_FLAG_CLEAR: assert property (
        sClear |=> (errFlags_q == 3'b000) && !errState_q)
        else $error("error clear had no effect");
    AST_FLAG_STICKY: assert property (
        (errFlags_q != 3'b000) && !errClear |=> $stable(errFlags_q))
        else $error("latched error flags changed");
    AST_ERR_CAUSE: assert property (
        $rose(errState_q) |-> ##[0:1] (errFlags_q != 3'b000))
        else $error("error state without a flag");
    AST_CKMISS: assert property (
        sMissing |-> errFlags_q != 3'b000)
        else $error("missing clock not flagged");
    AST_TGT_LEGAL: assert property (
        wrValid_q |-> wrTarget_q <= 3'h4)
        else $error("write with unknown target");
    AST_DATA_BOUND: assert property (
        wrValid_q && (wrTarget_q == `SBW_TGT_DATA_BOTH) |-> wrAddr_q < 10'h080)
        else $error("data memory frame beyond its bound");
    AST_RESET_IDLE: assert property (
        $rose(rst_b) |-> !wrValid_q && !errState_q && (errFlags_q == 3'b000) && !modeB_q)
        else $error("not idle after reset");
endmodule

// ===== verification/sbw_spi_master.sv
`timescale 1ns/1ns
module sbw_spi_master (
    // Clock
    input  wire clock,
    // Link pins
    output reg  sckPin,
    output reg  csPin_b,
    output reg  mosiPin,
    input  wire misoPin
);
    // Half of the 320 ns link period
    localparam HALF = 4;
    initial begin
        sckPin = 1'b0;
        csPin_b = 1'b1;
        mosiPin = 1'b1;
    end
    // ----------------------------------------
    // One whole word; reply read late in the high phase
    // ----------------------------------------
    task automatic xfer(input [15:0] w, input hold, output [15:0] r);
        integer i;
        begin
            csPin_b <= 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                mosiPin <= w[i];
                repeat (HALF) @(posedge clock);
                sckPin <= 1'b1;
                repeat (HALF) @(posedge clock);
                r[i] = misoPin;
                sckPin <= 1'b0;
            end
            repeat (HALF) @(posedge clock);
            // Released data line must not keep the last bit
            mosiPin <= ~mosiPin;
            if (!hold) csPin_b <= 1'b1;
            repeat (HALF) @(posedge clock);
        end
    endtask
    // Cut word: n clocks, then chip select released
    task automatic part(input integer n);
        integer i;
        begin
            csPin_b <= 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                repeat (HALF) @(posedge clock);
                sckPin <= 1'b1;
                repeat (HALF) @(posedge clock);
                sckPin <= 1'b0;
            end
            repeat (HALF) @(posedge clock);
            csPin_b <= 1'b1;
            repeat (HALF) @(posedge clock);
        end
    endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`include "sbw_map.vh"
module tb_top;
    // Short watchdog unit keeps the timeout run brief
    localparam WDU = 64;
    reg         clock;
    reg         rst_b;
    reg         wrReady;
    reg         clockMissing;
    reg         errClear;
    wire        sckPin, csPin_b, mosiPin, misoPin_q, wrValid_q, errState_q, modeB_q;
    wire [9:0]  wrAddr_q;
    wire [15:0] wrData_q;
    wire [2:0]  wrTarget_q, errFlags_q;
    integer     n_errors, n_compared, t, n, i, k;
    reg [28:0]  wrLog [$];
    reg [15:0]  r;
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    sbw_write_protocol #(.WDOG_UNIT(WDU)) dut (.clock(clock), .rst_b(rst_b),
        .sckPin(sckPin), .csPin_b(csPin_b), .mosiPin(mosiPin), .misoPin_q(misoPin_q),
        .wrValid_q(wrValid_q), .wrAddr_q(wrAddr_q), .wrData_q(wrData_q),
        .wrTarget_q(wrTarget_q), .wrReady(wrReady), .clockMissing(clockMissing),
        .errClear(errClear), .errState_q(errState_q), .errFlags_q(errFlags_q),
        .modeB_q(modeB_q));
    sbw_spi_master master (.clock(clock), .sckPin(sckPin), .csPin_b(csPin_b),
        .mosiPin(mosiPin), .misoPin(misoPin_q));
    always @(posedge clock) begin
        if (wrValid_q === 1'b1 && wrReady === 1'b1) wrLog.push_back({wrTarget_q, wrAddr_q, wrData_q});
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task xw(input [15:0] w, input hold, input [2:0] f);
        begin
            master.xfer(w, hold, r);
            chk(r, {`SBW_CHECK_PATTERN, f});
        end
    endtask
    task expWr(input [2:0] tg, input [9:0] a, input [15:0] d);
        integer w;
        begin
            w = 0;
            while (wrLog.size() == 0 && w < 400) begin
                @(posedge clock);
                w = w + 1;
            end
            chk(wrLog.size() > 0, 1);
            if (wrLog.size() > 0) chk(wrLog.pop_front(), {tg, a, d});
        end
    endtask
    task wr(input [9:0] a, input [15:0] d);
        begin
            xw({1'b0, a, 5'd1}, 1'b0, 3'b000);
            xw(d, 1'b0, 3'b000);
            expWr(3'h0, a, d);
        end
    endtask
    task pulseClr;
        begin
            errClear <= 1'b1;
            @(posedge clock);
            errClear <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
    task finish_test;
        begin
            $display("errors=%0d compared=%0d", n_errors, n_compared);
            if (n_errors == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_errors = 0;
        n_compared = 0;
        rst_b = 1'b0;
        wrReady = 1'b1;
        clockMissing = 1'b0;
        errClear = 1'b0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        chk({modeB_q, errState_q, errFlags_q}, 5'h00);
        xw({1'b0, 10'h194, 5'd2}, 1'b1, 3'b000);
        xw(16'h1234, 1'b1, 3'b000);
        xw(16'h5678, 1'b0, 3'b000);
        expWr(3'h0, 10'h194, 16'h1234);
        expWr(3'h0, 10'h195, 16'h5678);
        wr(`SBW_ADDR_PLEN_CH1, 16'h0003);
        wr(`SBW_ADDR_PLEN_CH2, 16'h0002);
        for (t = 1; t <= 5; t = t + 1) begin
            wr(`SBW_ADDR_TARGET_SEL, t);
            n = (t == 2) ? 2 : (t == 4) ? 128 : (t == 5) ? 0 : 3;
            xw(16'h0000, n > 0, 3'b000);
            for (i = 0; i < n; i = i + 1) begin
                xw(16'hA000 + i, i < n - 1, 3'b000);
                expWr(t, i, 16'hA000 + i);
            end
        end
        repeat (300) @(posedge clock);
        chk(wrLog.size(), 0);
        wr(`SBW_ADDR_TARGET_SEL, 16'h0004);
        // Stalled sink: both words must survive the buffer
        wrReady <= 1'b0;
        xw({1'b0, 10'h0C0, 5'd2}, 1'b1, 3'b000);
        xw(16'h0C01, 1'b1, 3'b000);
        xw(16'h0C02, 1'b0, 3'b000);
        chk(wrLog.size(), 0);
        wrReady <= 1'b1;
        expWr(3'h0, 10'h0C0, 16'h0C01);
        expWr(3'h0, 10'h0C1, 16'h0C02);
        // Inter-word timeout with the reset watchdog field
        xw({1'b0, 10'h100, 5'd3}, 1'b0, 3'b000);
        xw(16'h0D01, 1'b0, 3'b000);
        expWr(3'h0, 10'h100, 16'h0D01);
        k = 0;
        while (errState_q !== 1'b1 && k < 2000) begin
            @(posedge clock);
            k = k + 1;
        end
        chk(k >= 688 && k <= 712, 1);
        chk(errFlags_q, 3'b010);
        xw(16'h0D02, 1'b0, 3'b010);
        repeat (200) @(posedge clock);
        chk(wrLog.size(), 0);
        pulseClr;
        chk({errState_q, errFlags_q}, 4'h0);
        // Framing select high disables the watchdog
        wr(`SBW_ADDR_LINK_SETUP, 16'h0020);
        chk(modeB_q, 1);
        xw({1'b0, 10'h0A0, 5'd2}, 1'b1, 3'b000);
        xw(16'h0B01, 1'b1, 3'b000);
        repeat (1000) @(posedge clock);
        chk(errState_q, 0);
        xw(16'h0B02, 1'b0, 3'b000);
        expWr(3'h0, 10'h0A0, 16'h0B01);
        expWr(3'h0, 10'h0A1, 16'h0B02);
        wr(`SBW_ADDR_LINK_SETUP, 16'h000A);
        chk(modeB_q, 0);
        // Missing system clock during a frame
        clockMissing <= 1'b1;
        master.xfer({1'b0, 10'h194, 5'd1}, 1'b1, r);
        clockMissing <= 1'b0;
        chk(errFlags_q, 3'b100);
        xw(16'h0042, 1'b0, 3'b100);
        expWr(3'h0, 10'h194, 16'h0042);
        pulseClr;
        chk(errFlags_q, 3'b000);
        // Cut data word raises the bit-count flag
        xw({1'b0, 10'h0E0, 5'd1}, 1'b0, 3'b000);
        master.part(5);
        repeat (8) @(posedge clock);
        chk({errState_q, errFlags_q}, 4'h9);
        pulseClr;
        chk({errState_q, errFlags_q}, 4'h0);
        finish_test;
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_errors = n_errors + 1;
        finish_test;
    end
endmodule
bind sbw_write_protocol sbw_props #(.WDOG_UNIT(WDOG_UNIT)) uProps (.clock(clock),
    .rst_b(rst_b), .sckPin(sckPin), .csPin_b(csPin_b), .mosiPin(mosiPin),
    .misoPin_q(misoPin_q), .wrValid_q(wrValid_q), .wrAddr_q(wrAddr_q),
    .wrData_q(wrData_q), .wrTarget_q(wrTarget_q), .wrReady(wrReady),
    .clockMissing(clockMissing), .errClear(errClear), .errState_q(errState_q),
    .errFlags_q(errFlags_q), .modeB_q(modeB_q));
